//--- rtl/eac_pkg.sv
package eac_pkg;
  // Register byte addresses (APB, one word each)
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_ADDR   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Control register fields
  localparam int BIT_RD_STB  = 0;
  localparam int BIT_PRG_STB = 1;
  localparam int BIT_ARM     = 2;
  localparam int BIT_RIE     = 3;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;
  // Status register fields
  localparam int BIT_GIE     = 0;
  localparam int BIT_FLASH   = 1;
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  // Mode encodings
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_WRITE  = 2'h2;
  localparam logic [1:0] MODE_RSVD   = 2'h3;
  localparam logic [1:0] MODE_RST    = 2'h0;
  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int T_ATOMIC_US   = 3400;
  localparam int T_SINGLE_US   = 1800;
  localparam int CYC_ATOMIC    = T_ATOMIC_US * (CLK_HZ / 1_000_000);
  localparam int CYC_SINGLE    = T_SINGLE_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0] ARM_CYCLES   = 3'h4;
  localparam logic [2:0] PRG_STALL    = 3'h2;
  localparam logic [2:0] RD_STALL     = 3'h4;
  localparam int CNT_W = 18;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
endpackage

//--- rtl/eac_array.sv
`timescale 1ns/10ps
module eac_array
  import eac_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Write port
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  // Read port
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];
endmodule

//--- rtl/eac_top.sv
// Overview of operation
// - Data register sources writes, receives read bytes
// - Control bits 7 and 6 read zero
// - Mode bits pick atomic, erase or write
// - Mode writes ignored while programming strobe set
// - Reset clears mode unless programming busy
// - Ready request held while enabled and idle
// - Arm bit self-clears after four cycles
// - Strobe while armed starts programming
// - Strobe without arm does nothing
// - No programming while flash self-programming active
// - Strobe clears when programming time elapses
// - Programming strobe stalls CPU two cycles
// - Read strobe loads byte immediately
// - Read strobe stalls CPU four cycles
// - Busy blocks reads and address changes
// - Control bit layout fixed
// - Twelve-bit address, upper bits read zero
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module eac_top
  import eac_pkg::*;
#(
  parameter int unsigned P_CYC_ATOMIC = CYC_ATOMIC,
  parameter int unsigned P_CYC_SINGLE = CYC_SINGLE
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // CPU side
  input  wire logic        i_global_irq_en,
  input  wire logic        i_flash_selfprog_active,
  output logic             o_ready_irq,
  output logic             o_cpu_stall,
  output logic             o_busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_PROG} eac_state_t;

  eac_state_t              state_q, state_d;
  logic [DATA_W-1:0]       data_q, data_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [1:0]              mode_q, mode_d;
  logic                    rie_q, rie_d;
  logic                    arm_q, arm_d;
  logic [2:0]              arm_cnt_q, arm_cnt_d;
  logic                    prg_q = 1'b0;
  logic                    prg_d;
  logic [CNT_W-1:0]        tmr_q, tmr_d;
  logic [2:0]              stall_q, stall_d;
  logic [1:0]              op_q, op_d;
  logic [31:0]             prdata_d;
  logic                    irq_d;

  function automatic logic [CNT_W-1:0] prog_cycles(input logic [1:0] m);
    prog_cycles = (m == MODE_ATOMIC) ? CNT_W'(P_CYC_ATOMIC) : CNT_W'(P_CYC_SINGLE);
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_b, input logic [7:0] new_b,
                                            input logic [1:0] m);
    case (m)
      MODE_ATOMIC: merge_byte = new_b;
      MODE_ERASE:  merge_byte = ERASED_BYTE;
      MODE_WRITE:  merge_byte = old_b & new_b;
      default:     merge_byte = old_b;
    endcase
  endfunction

  // Bus decode
  wire       acc      = i_psel & i_penable;
  wire       wr       = acc & i_pwrite;
  wire       rd       = acc & ~i_pwrite;
  wire       hit_data = (i_paddr == ADDR_DATA);
  wire       hit_ctrl = (i_paddr == ADDR_CTRL);
  wire       hit_addr = (i_paddr == ADDR_ADDR);
  wire       hit_stat = (i_paddr == ADDR_STATUS);
  wire       mapped   = hit_data | hit_ctrl | hit_addr | hit_stat;
  wire       wr_ctrl  = wr & hit_ctrl;
  wire [7:0] wbyte    = i_pwdata[7:0];

  // Strobe qualification
  wire prog_go  = wr_ctrl & wbyte[BIT_PRG_STB] & arm_q & ~prg_q
                & ~i_flash_selfprog_active & (mode_q != MODE_RSVD);
  wire read_go  = wr_ctrl & wbyte[BIT_RD_STB] & ~prg_q;
  wire prog_end = prg_q & (tmr_q == '0);

  // Array
  logic [DATA_W-1:0] mem_rdata;
  wire  [DATA_W-1:0] mem_wdata = merge_byte(mem_rdata, data_q, op_q);
  eac_array u_array (
    .i_clk   (i_clk),
    .i_we    (prog_end),
    .i_waddr (addr_q),
    .i_wdata (mem_wdata),
    .i_raddr (addr_q),
    .o_rdata (mem_rdata)
  );

  wire [7:0] ctrl_rd = {2'b00, mode_q, rie_q, arm_q, prg_q, 1'b0};

  always_comb begin
    state_d   = state_q;
    data_d    = data_q;
    addr_d    = addr_q;
    mode_d    = mode_q;
    rie_d     = rie_q;
    arm_d     = arm_q;
    arm_cnt_d = arm_cnt_q;
    prg_d     = prg_q;
    tmr_d     = tmr_q;
    stall_d   = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
    op_d      = op_q;
    if (wr & hit_data) begin
      data_d = wbyte;
    end
    if (wr & hit_addr & ~prg_q) begin
      addr_d = i_pwdata[ADDR_W-1:0];
    end
    if (arm_q) begin
      if (arm_cnt_q == 3'h1) begin
        arm_d = 1'b0;
      end
      arm_cnt_d = arm_cnt_q - 3'h1;
    end
    if (wr_ctrl) begin
      rie_d = wbyte[BIT_RIE];
      if (!prg_q) begin
        mode_d = wbyte[BIT_MODE_HI:BIT_MODE_LO];
      end
      if (wbyte[BIT_ARM] & ~wbyte[BIT_PRG_STB]) begin
        arm_d     = 1'b1;
        arm_cnt_d = ARM_CYCLES;
      end
    end
    if (read_go) begin
      data_d  = mem_rdata;
      stall_d = RD_STALL;
    end
    case (state_q)
      ST_IDLE: begin
        if (prog_go) begin
          prg_d   = 1'b1;
          op_d    = mode_q;
          tmr_d   = prog_cycles(mode_q);
          stall_d = PRG_STALL;
          arm_d   = 1'b0;
          state_d = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_end) begin
          prg_d   = 1'b0;
          state_d = ST_IDLE;
        end else begin
          tmr_d = tmr_q - CNT_W'(1);
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_data) prdata_d = {24'h00_0000, data_q};
    if (hit_ctrl) prdata_d = {24'h00_0000, ctrl_rd};
    if (hit_addr) prdata_d = {20'h0_0000, addr_q};
    if (hit_stat) prdata_d = {30'h0000_0000, i_flash_selfprog_active, i_global_irq_en};
  end

  assign irq_d = rie_d & i_global_irq_en & ~prg_d;

  always_ff @(posedge i_clk) begin
    data_q <= data_d;
    addr_q <= addr_d;
    tmr_q  <= tmr_d;
    op_q   <= op_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q   <= (prg_q & ~prog_end) ? ST_PROG : ST_IDLE;
      rie_q     <= 1'b0;
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
      stall_q   <= 3'h0;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_ready_irq <= 1'b0;
      o_cpu_stall <= 1'b0;
      o_busy    <= prg_q & ~prog_end;
    end else begin
      state_q   <= state_d;
      rie_q     <= rie_d;
      arm_q     <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      stall_q   <= stall_d;
      o_prdata  <= (i_psel & ~i_penable & ~i_pwrite) ? prdata_d : 32'h0000_0000;
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      o_ready_irq <= irq_d;
      o_cpu_stall <= stall_d != 3'h0;
      o_busy    <= prg_d;
    end
  end

  // Programming keeps running through reset; mode kept while busy
  always_ff @(posedge i_clk) begin
    if (i_sys_rst && !prg_q) begin
      mode_q <= MODE_RST;
    end else if (i_sys_rst) begin
      mode_q <= mode_q;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prg_q <= prg_q & ~prog_end;
    end else begin
      prg_q <= prg_d;
    end
  end
endmodule

//--- verif/eac_checker.sv
`timescale 1ns/10ps
module eac_checker
  import eac_pkg::*;
#(
  parameter int unsigned P_CYC_ATOMIC = CYC_ATOMIC,
  parameter int unsigned P_CYC_SINGLE = CYC_SINGLE
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // APB
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  // CPU side
  input  wire logic        i_global_irq_en,
  input  wire logic        i_flash_selfprog_active,
  input  wire logic        o_ready_irq,
  input  wire logic        o_cpu_stall,
  input  wire logic        o_busy
);
  logic [31:0] cnt_q;
  wire         rd_w = o_pready && !i_pwrite;
  // Busy cycle count
  always_ff @(posedge i_clk) cnt_q <= o_busy ? cnt_q + 32'h1 : 32'h0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  pready_time_a: assert property (i_psel && !i_penable |=> o_pready) else $error("ready late");
  pready_only_a: assert property (o_pready |-> i_psel && i_penable) else $error("stray ready");
  idle_data_a: assert property (!rd_w |-> o_prdata == 32'h0) else $error("stray read data");
  ctrl_rsvd_a: assert property (rd_w && i_paddr == ADDR_CTRL |-> o_prdata[31:6] == 26'h0
    && !o_prdata[0]) else $error("control reserved bits set");
  data_width_a: assert property (rd_w && i_paddr == ADDR_DATA |-> o_prdata[31:8] == 24'h0)
    else $error("data upper bits set");
  addr_width_a: assert property (rd_w && i_paddr == ADDR_ADDR |-> o_prdata[31:12] == 20'h0)
    else $error("address upper bits set");
  irq_busy_a: assert property (o_busy && $past(o_busy) |-> !o_ready_irq)
    else $error("ready request while busy");
  irq_gie_a: assert property (!i_global_irq_en && !$past(i_global_irq_en) |-> !o_ready_irq)
    else $error("ready request while masked");
  stall_len_a: assert property ($rose(o_cpu_stall) |-> o_cpu_stall [*2] ##[1:3] !o_cpu_stall)
    else $error("stall length");
  busy_time_a: assert property ($fell(o_busy) |-> (cnt_q >= P_CYC_SINGLE
    && cnt_q <= P_CYC_SINGLE + 2) || (cnt_q >= P_CYC_ATOMIC && cnt_q <= P_CYC_ATOMIC + 2))
    else $error("programming time");
  flash_block_a: assert property ($rose(o_busy) |-> !$past(i_flash_selfprog_active))
    else $error("programmed during flash write");
  map_err_a: assert property (o_pready && i_paddr[7:4] == 4'h0 && i_paddr[1:0] == 2'h0
    |-> !o_pslverr) else $error("error on mapped address");
endmodule
bind eac_top eac_checker #(.P_CYC_ATOMIC(P_CYC_ATOMIC), .P_CYC_SINGLE(P_CYC_SINGLE)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_global_irq_en(i_global_irq_en),
  .i_flash_selfprog_active(i_flash_selfprog_active), .o_ready_irq(o_ready_irq),
  .o_cpu_stall(o_cpu_stall), .o_busy(o_busy));

//--- verif/eeprom_access_control_test.sv
`timescale 1ns/10ps
module eeprom_access_control_test;
  import eac_pkg::*;
  localparam int PA = 60;
  localparam int PS = 30;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic        i_global_irq_en = 1'b1;
  logic        i_flash_selfprog_active = 1'b0;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_ready_irq, o_cpu_stall, o_busy, err;
  logic [31:0] seed = 32'h12738DBA;
  logic [31:0] rd;
  logic [7:0]  mem, d;
  logic [11:0] a;
  logic [1:0]  m;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n, p;
  always #12.5 i_clk = ~i_clk;
  eac_top #(.P_CYC_ATOMIC(PA), .P_CYC_SINGLE(PS)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_global_irq_en(i_global_irq_en),
    .i_flash_selfprog_active(i_flash_selfprog_active), .o_ready_irq(o_ready_irq),
    .o_cpu_stall(o_cpu_stall), .o_busy(o_busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [7:0] nv_next(input logic [1:0] md, input logic [7:0] o,
                                         input logic [7:0] v);
    return md == MODE_ERASE ? ERASED_BYTE : (md == MODE_WRITE ? (o & v) : v);
  endfunction
  task automatic complete_run;
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, ad, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic wait_idle;
    n = 0;
    while (o_busy !== 1'b0 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  task automatic pulse_reset;
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    apb(0, ADDR_CTRL, 0);
    chk({rd[5:4], rd[2:1]}, 0);
    apb(0, 8'h40, 0);
    chk({err, rd}, {1'b1, 32'h0});
    seed = lfsr(seed);
    a = seed[11:0];
    for (int i = 0; i < 6; i++) begin
      m = i % 3 == 1 ? MODE_WRITE : (i % 3 == 2 ? MODE_ERASE : MODE_ATOMIC);
      p = m == MODE_ATOMIC ? PA : PS;
      seed = lfsr(seed);
      d = seed[7:0];
      i_global_irq_en <= 1'b0;
      apb(1, ADDR_ADDR, a);
      apb(1, ADDR_DATA, d);
      apb(1, ADDR_CTRL, {m, 4'hC});
      apb(1, ADDR_CTRL, {m, 4'hE});
      i_global_irq_en <= 1'b1;
      apb(1, ADDR_ADDR, ~a);
      apb(1, ADDR_CTRL, {~m, 4'h9});
      apb(0, ADDR_CTRL, 0);
      chk(rd[5:0], {m, 4'hA});
      chk(o_ready_irq, 0);
      wait_idle();
      chk(n + 9 >= p && n + 9 <= p + 4, 1);
      apb(1, ADDR_CTRL, {m, 4'h9});
      apb(0, ADDR_DATA, 0);
      mem = nv_next(m, mem, d);
      chk(rd, mem);
      apb(0, ADDR_ADDR, 0);
      chk(rd, a);
      chk(o_ready_irq, 1);
    end
    for (int k = 0; k < 4; k++) begin
      i_flash_selfprog_active <= k == 2;
      i_global_irq_en <= k != 3;
      apb(1, ADDR_CTRL, k == 0 ? 8'h00 : (k == 1 ? 8'h34 : 8'h04));
      if (k == 3) begin
        apb(0, ADDR_CTRL, 0);
        chk(rd[2], 1);
        repeat (4) @(posedge i_clk);
      end
      apb(1, ADDR_CTRL, k == 1 ? 8'h3A : 8'h0A);
      repeat (3) @(posedge i_clk);
      chk(o_busy, 0);
    end
    i_flash_selfprog_active <= 1'b0;
    i_global_irq_en <= 1'b1;
    apb(1, ADDR_CTRL, 8'h14);
    apb(1, ADDR_CTRL, 8'h16);
    pulse_reset();
    apb(0, ADDR_CTRL, 0);
    chk(rd[5:4], MODE_ERASE);
    wait_idle();
    pulse_reset();
    apb(0, ADDR_CTRL, 0);
    chk(rd[5:4], MODE_RST);
    apb(1, ADDR_CTRL, 0);
    repeat (3) @(posedge i_clk);
    chk(o_ready_irq, 0);
    complete_run();
  end
endmodule
